// >>> hdl/switch_pkg.sv
// Constants, register map and enumerations for the weekly two-circuit time switch.
// Assumes a 25 MHz core clock and a one-per-second tick from the surrounding time base.
package switch_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_KHZ         = 25000;
    localparam int CONTACT_HOLD_MS = 200;
    localparam int HOLD_CYC        = CONTACT_HOLD_MS * CLK_KHZ;

    localparam logic [5:0]  SEC_LAST     = 6'h3b;
    localparam logic [5:0]  MIN_LAST     = 6'h3b;
    localparam logic [4:0]  HOUR_LAST    = 5'h17;
    localparam logic [2:0]  DAY_LAST     = 3'h6;
    localparam logic [10:0] MIN_PER_HOUR = 11'h03c;
    localparam logic [11:0] SEC_PER_MIN  = 12'h03c;
    localparam logic [3:0]  OVR_WEEK     = 4'h7;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [5:0] A_TIME     = 6'h00;
    localparam logic [5:0] A_SEL      = 6'h04;
    localparam logic [5:0] A_STAGE0   = 6'h08;
    localparam logic [5:0] A_STAGE1   = 6'h0c;
    localparam logic [5:0] A_CMD      = 6'h10;
    localparam logic [5:0] A_OVERRIDE = 6'h14;
    localparam logic [5:0] A_STATUS   = 6'h18;
    localparam logic [5:0] A_REVIEW   = 6'h1c;
    localparam logic [5:0] A_MONITOR  = 6'h20;

    localparam int CMD_COMMIT = 0;
    localparam int CMD_CANCEL = 1;
    localparam int CMD_CURSOR = 2;
    localparam int CMD_TOGGLE = 3;
    localparam int CMD_REVIEW = 4;

    // ****************************************
    // Entry word layout
    // ****************************************
    localparam int ENTRIES    = 8;
    localparam int W0_DAYS    = 0;
    localparam int W0_CYC     = 7;
    localparam int W0_VALID   = 8;
    localparam int W0_ON      = 9;
    localparam int W0_OFF     = 20;
    localparam int W1_WIDTH   = 0;
    localparam int W1_UNIT    = 6;
    localparam int W1_CYC_ON  = 7;
    localparam int W1_CYC_OFF = 13;

    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_PROG1 = 2'b01,
        MODE_PROG2 = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        FORCE_AUTO = 2'b00,
        FORCE_ON   = 2'b01,
        FORCE_OFF  = 2'b10
    } force_t;
endpackage

// >>> hdl/time_switch.sv
// Weekly two-circuit time switch: clock, programs, override, restart and register slave.
// Assumes sec_tick_in pulses one cycle per second and all panel inputs are synchronous.
//
// Summary of operation
// - Mode selector chooses program circuit one, program circuit two, or run.
// - Both outputs stay off while either programming position is selected.
// - Per-circuit switch forces on, forces off, or follows the program.
// - Output-type switch selects timer/cyclic or pulse interpretation of programs.
// - Timer entries switch on at on minute and off at off minute.
// - Pulse entries assert for 1..59 seconds or 1..59 minutes from on minute.
// - Cyclic entries alternate on/off minute durations between start and stop.
// - Automatic restart resumes programs as soon as power returns.
// - Manual restart waits for contact open then closed held 0.2 s.
// - Day override runs another day's program for one week from next day.
// - Cancel erases the programmed circuit, or in run mode the override.
// - Conflicting settings: the earlier on time keeps the output on.
// - Overlapping or abutting settings keep the output on without a gap.
// - Multi-day on ends at the first off time reached on any day.
// - Equal on and off minute on one day produce no action.
// - Time and day can be set at any time, also while running.
// - Changing the output type clears the stored programs.
// - Review steps entry order in programming, execution order in run.
// - Day cursor steps right one day; toggle key flips that day.
// - Indicator shows automatic operation; monitor shows the active entry.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

module time_switch #(
    parameter int unsigned HOLD_CYC = switch_pkg::HOLD_CYC
) (
    input  wire logic               core_clk_in,          // 25 MHz clock
    input  wire logic               nrst_in,              // Async reset, active low
    input  wire logic [5:0]         avs_address_in,       // Byte address
    input  wire logic               avs_read_in,          // Read request
    input  wire logic               avs_write_in,         // Write request
    input  wire logic [31:0]        avs_writedata_in,     // Write data
    output logic      [31:0]        avs_readdata_out,     // Read data
    output logic                    avs_waitrequest_out,  // Stall
    input  wire logic               sec_tick_in,          // One pulse per second
    input  wire switch_pkg::mode_t  mode_sel_in,          // Mode selector
    input  wire switch_pkg::force_t force_c1_in,          // Circuit 1 on/auto/off
    input  wire switch_pkg::force_t force_c2_in,          // Circuit 2 on/auto/off
    input  wire logic               out_type_in,          // 0 timer, 1 pulse
    input  wire logic               restart_auto_in,      // 1 auto restart
    input  wire logic               restart_contact_in,   // External contact closed
    output logic      [1:0]         circuit_out,          // Switched circuits
    output logic                    auto_ind_out          // Automatic operation lamp
);
    import switch_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic [5:0]  sec, min;
    logic [4:0]  hour;
    logic [2:0]  day;
    logic [31:0] e0 [ENTRIES];
    logic [18:0] e1 [ENTRIES];
    logic [31:0] stage0;
    logic [18:0] stage1;
    logic [2:0]  sel, cursor, rev_idx, rev_next, mon_idx, eday;
    logic [6:0]  work_days, ovr_mask;
    logic [2:0]  ovr_src;
    logic        ovr_armed, run_enable, seen_open, done, min_evt, day_evt, type_q;
    logic        mon_ok, running, prog;
    logic [3:0]  ovr_days;
    logic [22:0] hold_cnt;
    logic        win [ENTRIES];
    logic        phase [ENTRIES];
    logic [5:0]  ccnt [ENTRIES];
    logic [11:0] pcnt [ENTRIES];
    logic [7:0]  hit_on, hit_off, contrib, vld;
    logic [10:0] mod;
    logic [4:0]  cmd;
    logic [31:0] rd_mux;
    logic        wr_ok, time_wr;

    function automatic logic [10:0] on_of(input logic [31:0] w);
        return w[W0_ON +: 11];
    endfunction

    function automatic logic [10:0] off_of(input logic [31:0] w);
        return w[W0_OFF +: 11];
    endfunction

    function automatic logic [11:0] width_secs(input logic [18:0] w);
        return w[W1_UNIT] ? 12'(w[W1_WIDTH +: 6]) * SEC_PER_MIN : 12'(w[W1_WIDTH +: 6]);
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~done;
    assign wr_ok   = avs_write_in & done;
    assign time_wr = wr_ok && avs_address_in == A_TIME;
    assign cmd     = (wr_ok && avs_address_in == A_CMD) ? avs_writedata_in[4:0] : 5'h00;
    assign running = mode_sel_in == MODE_RUN && run_enable;
    assign prog    = mode_sel_in != MODE_RUN;
    assign mod     = 11'(hour) * MIN_PER_HOUR + 11'(min);
    assign eday    = (ovr_armed && ovr_days != 4'h0 && ovr_mask[day]) ? ovr_src : day;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done <= 1'b0;
        end else begin
            done <= (avs_read_in | avs_write_in) & ~done;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !done) begin
            avs_readdata_out <= rd_mux;
        end
    end

    always_comb begin
        case (avs_address_in)
            A_TIME:     rd_mux = {12'h000, day, hour, min, sec};
            A_SEL:      rd_mux = {29'h0, sel};
            A_STAGE0:   rd_mux = stage0;
            A_STAGE1:   rd_mux = {13'h0000, stage1};
            A_OVERRIDE: rd_mux = {22'h0, ovr_src, ovr_mask};
            A_STATUS:   rd_mux = {15'h0000, rev_idx, work_days, cursor,
                                  ovr_armed, run_enable, circuit_out};
            A_REVIEW:   rd_mux = {1'b0, e0[rev_idx][30:0]};
            A_MONITOR:  rd_mux = {mon_ok, e0[mon_idx][30:0]};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Time of day and weekday
    // ****************************************
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sec  <= 6'h00;
            min  <= 6'h00;
            hour <= 5'h00;
            day  <= 3'h0;
        end else if (time_wr) begin
            sec  <= avs_writedata_in[5:0];
            min  <= avs_writedata_in[11:6];
            hour <= avs_writedata_in[16:12];
            day  <= avs_writedata_in[19:17];
        end else if (sec_tick_in) begin
            sec <= (sec == SEC_LAST) ? 6'h00 : sec + 6'h01;
            if (sec == SEC_LAST) begin
                min <= (min == MIN_LAST) ? 6'h00 : min + 6'h01;
                if (min == MIN_LAST) begin
                    hour <= (hour == HOUR_LAST) ? 5'h00 : hour + 5'h01;
                    if (hour == HOUR_LAST) begin
                        day <= (day == DAY_LAST) ? 3'h0 : day + 3'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            min_evt <= 1'b0;
            day_evt <= 1'b0;
        end else begin
            min_evt <= sec_tick_in && sec == SEC_LAST && !time_wr;
            day_evt <= sec_tick_in && sec == SEC_LAST && min == MIN_LAST
                       && hour == HOUR_LAST && !time_wr;
        end
    end

    // ****************************************
    // Power restoration
    // ****************************************
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_enable <= 1'b0;
            seen_open  <= 1'b0;
            hold_cnt   <= 23'h000000;
        end else if (!run_enable) begin
            if (restart_auto_in) begin
                run_enable <= 1'b1;
            end else if (!restart_contact_in) begin
                seen_open <= 1'b1;
                hold_cnt  <= 23'h000000;
            end else if (seen_open) begin
                if (hold_cnt == 23'(HOLD_CYC - 1)) begin
                    run_enable <= 1'b1;
                end else begin
                    hold_cnt <= hold_cnt + 23'h000001;
                end
            end
        end
    end

    // ****************************************
    // Panel keys: staging, cursor, review, override
    // ****************************************
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage0    <= 32'h0000_0000;
            stage1    <= 19'h00000;
            sel       <= 3'h0;
            cursor    <= 3'h0;
            work_days <= 7'h00;
            rev_idx   <= 3'h0;
        end else begin
            if (wr_ok && avs_address_in == A_STAGE0) stage0 <= avs_writedata_in;
            if (wr_ok && avs_address_in == A_STAGE1) stage1 <= avs_writedata_in[18:0];
            if (wr_ok && avs_address_in == A_SEL) sel <= avs_writedata_in[2:0];
            if (cmd[CMD_CURSOR]) cursor <= (cursor == DAY_LAST) ? 3'h0 : cursor + 3'h1;
            if (cmd[CMD_TOGGLE]) work_days[cursor] <= ~work_days[cursor];
            if (cmd[CMD_REVIEW]) rev_idx <= rev_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ovr_mask  <= 7'h00;
            ovr_src   <= 3'h0;
            ovr_armed <= 1'b0;
            ovr_days  <= 4'h0;
        end else if (cmd[CMD_CANCEL] && !prog) begin
            ovr_armed <= 1'b0;
        end else if (wr_ok && avs_address_in == A_OVERRIDE) begin
            ovr_mask  <= avs_writedata_in[6:0];
            ovr_src   <= avs_writedata_in[9:7];
            ovr_armed <= 1'b1;
            ovr_days  <= 4'h0;
        end else if (day_evt && ovr_armed) begin
            if (ovr_days == OVR_WEEK) begin
                ovr_armed <= 1'b0;
            end else begin
                ovr_days <= ovr_days + 4'h1;
            end
        end
    end

    // ****************************************
    // Program store
    // ****************************************
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            type_q <= 1'b0;
            for (int i = 0; i < ENTRIES; i++) begin
                e0[i] <= 32'h0000_0000;
                e1[i] <= 19'h00000;
            end
        end else begin
            type_q <= out_type_in;
            for (int i = 0; i < ENTRIES; i++) begin
                if (type_q != out_type_in) begin
                    e0[i][W0_VALID] <= 1'b0;
                end else if (cmd[CMD_CANCEL] && prog && (i >= 4) == (mode_sel_in == MODE_PROG2)) begin
                    e0[i][W0_VALID] <= 1'b0;
                end else if (cmd[CMD_COMMIT] && prog
                             && 3'(i) == {mode_sel_in == MODE_PROG2, sel[1:0]}) begin
                    e0[i] <= {1'b0, off_of(stage0), on_of(stage0), 1'b1,
                              stage0[W0_CYC], work_days};
                    e1[i] <= stage1;
                end
            end
        end
    end

    // ****************************************
    // Evaluation
    // ****************************************
    always_comb begin
        for (int i = 0; i < ENTRIES; i++) begin
            vld[i]     = e0[i][W0_VALID];
            hit_on[i]  = mod == on_of(e0[i]) && e0[i][W0_DAYS + int'(eday)]
                         && on_of(e0[i]) != off_of(e0[i]);
            hit_off[i] = mod == off_of(e0[i]) && on_of(e0[i]) != off_of(e0[i]);
            contrib[i] = out_type_in ? pcnt[i] != 12'h000
                                     : win[i] && (!e0[i][W0_CYC] || phase[i]);
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < ENTRIES; i++) begin
                win[i]   <= 1'b0;
                phase[i] <= 1'b0;
                ccnt[i]  <= 6'h00;
                pcnt[i]  <= 12'h000;
            end
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (!running || !vld[i]) begin
                    win[i]  <= 1'b0;
                    pcnt[i] <= 12'h000;
                end else if (min_evt) begin
                    if (out_type_in) begin
                        if (hit_on[i]) pcnt[i] <= width_secs(e1[i]);
                    end else if (hit_on[i]) begin
                        win[i]   <= 1'b1;
                        phase[i] <= 1'b1;
                        ccnt[i]  <= e1[i][W1_CYC_ON +: 6];
                    end else if (hit_off[i]) begin
                        win[i] <= 1'b0;
                    end else if (e0[i][W0_CYC] && win[i]) begin
                        if (ccnt[i] <= 6'h01) begin
                            phase[i] <= ~phase[i];
                            ccnt[i]  <= phase[i] ? e1[i][W1_CYC_OFF +: 6]
                                                 : e1[i][W1_CYC_ON +: 6];
                        end else begin
                            ccnt[i] <= ccnt[i] - 6'h01;
                        end
                    end
                end else if (sec_tick_in && pcnt[i] != 12'h000) begin
                    pcnt[i] <= pcnt[i] - 12'h001;
                end
            end
        end
    end

    // Review order and monitored entry
    always_comb begin
        logic [13:0] k, cur, best_gt, best_any;
        logic        elig;
        k        = 14'h0000;
        elig     = 1'b0;
        best_gt  = 14'h3fff;
        best_any = 14'h3fff;
        cur      = {prog ? 11'h000 : on_of(e0[rev_idx]), rev_idx};
        mon_ok   = 1'b0;
        mon_idx  = 3'h0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            k    = {prog ? 11'h000 : on_of(e0[i]), 3'(i)};
            elig = vld[i] && (prog ? (i >= 4) == (mode_sel_in == MODE_PROG2)
                                   : e0[i][W0_DAYS + int'(cursor)]);
            if (elig && k > cur && k < best_gt) best_gt = k;
            if (elig && k < best_any) best_any = k;
            if (contrib[i] && (i >= 4) == sel[2]) begin
                mon_ok  = 1'b1;
                mon_idx = 3'(i);
            end
        end
        rev_next = (best_gt != 14'h3fff) ? best_gt[2:0]
                 : (best_any != 14'h3fff) ? best_any[2:0] : rev_idx;
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            circuit_out  <= 2'b00;
            auto_ind_out <= 1'b0;
        end else begin
            auto_ind_out <= running;
            if (prog) begin
                circuit_out <= 2'b00;
            end else begin
                case (force_c1_in)
                    FORCE_ON:  circuit_out[0] <= 1'b1;
                    FORCE_OFF: circuit_out[0] <= 1'b0;
                    default:   circuit_out[0] <= running && |contrib[3:0];
                endcase
                case (force_c2_in)
                    FORCE_ON:  circuit_out[1] <= 1'b1;
                    FORCE_OFF: circuit_out[1] <= 1'b0;
                    default:   circuit_out[1] <= running && |contrib[7:4];
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_req;
        (avs_read_in || avs_write_in) && !done;
    endsequence
    sequence s_pulse_hit;
        min_evt && running && out_type_in && vld[0] && hit_on[0];
    endsequence

    property p_bus;      s_req |=> !avs_waitrequest_out; endproperty
    property p_prog_off; prog |=> circuit_out == 2'b00; endproperty
    property p_force_on; !prog && force_c1_in == FORCE_ON |=> circuit_out[0]; endproperty
    property p_force_off; !prog && force_c2_in == FORCE_OFF |=> !circuit_out[1]; endproperty
    property p_auto_ind; auto_ind_out |-> $past(run_enable) && !$past(prog); endproperty
    property p_auto_rst; !run_enable && restart_auto_in |=> run_enable; endproperty
    property p_manual;
        $rose(run_enable) && !$past(restart_auto_in)
            |-> $past(restart_contact_in) && $past(hold_cnt) == 23'(HOLD_CYC - 1);
    endproperty
    property p_pulse;
        s_pulse_hit ##1 !sec_tick_in |-> pcnt[0] == width_secs(e1[0]) && contrib[0];
    endproperty
    property p_same_min;
        min_evt && !out_type_in && on_of(e0[0]) == off_of(e0[0]) && !win[0] |=> !win[0];
    endproperty
    property p_ovr_week; ovr_armed |-> ovr_days <= OVR_WEEK; endproperty
    property p_cancel;   cmd[CMD_CANCEL] && !prog |=> !ovr_armed; endproperty
    property p_type_clr; type_q != out_type_in |=> vld == 8'h00; endproperty
    property p_sec_wrap; sec_tick_in && sec == SEC_LAST && !time_wr |=> sec == 6'h00 && min_evt;
    endproperty

    a_bus:       assert property (p_bus) else $error("waitrequest not released");
    a_prog_off:  assert property (p_prog_off) else $error("output on while programming");
    a_force_on:  assert property (p_force_on) else $error("forced on ignored");
    a_force_off: assert property (p_force_off) else $error("forced off ignored");
    a_auto_ind:  assert property (p_auto_ind) else $error("indicator without run");
    a_auto_rst:  assert property (p_auto_rst) else $error("auto restart missing");
    a_manual:    assert property (p_manual) else $error("manual restart too early");
    a_pulse:     assert property (p_pulse) else $error("pulse width wrong");
    a_same_min:  assert property (p_same_min) else $error("equal on/off acted");
    a_ovr_week:  assert property (p_ovr_week) else $error("override beyond a week");
    a_cancel:    assert property (p_cancel) else $error("override not cancelled");
    a_type_clr:  assert property (p_type_clr) else $error("program kept on type change");
    a_sec_wrap:  assert property (p_sec_wrap) else $error("second counter wrap");

endmodule // time_switch

// >>> verif/panel_model.sv
// Front-panel partner: external restart contact for the weekly time switch.
// Assumes one clock shared with the switch; close_in is a one-cycle request.
`timescale 1ns/1ps

module panel_model #(
    parameter int HOLD = 8
) (
    input  wire logic core_clk_in,  // Shared clock
    input  wire logic close_in,     // Request one contact closure
    output logic      contact_out   // Contact, 1 = closed
);
    int n = 0;
    // Open first, then closed a little longer than the hold time
    always @(posedge core_clk_in) begin
        if (close_in) n <= HOLD + 2;
        else if (n != 0) n <= n - 1;
    end
    assign contact_out = (n != 0);
endmodule // panel_model

// >>> verif/tb.sv
// Self-checking bench for the weekly time switch: restart, force, timer, cancel, pulse, bus.
// Assumes HOLD_CYC shortened to 8 and a bench-driven second tick.
`timescale 1ns/1ps

module tb;
    import switch_pkg::*;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, tick = 0, otype = 0, ra = 0, cl = 0, cont;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic wreq, ind;
    logic [1:0] co;
    mode_t mode = MODE_RUN;
    force_t f1 = FORCE_AUTO, f2 = FORCE_AUTO;
    int fail_count = 0, check_count = 0;
    time_switch #(.HOLD_CYC(8)) u_time_switch (.core_clk_in(clk), .nrst_in(nrst),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .sec_tick_in(tick),
        .mode_sel_in(mode), .force_c1_in(f1), .force_c2_in(f2), .out_type_in(otype),
        .restart_auto_in(ra), .restart_contact_in(cont), .circuit_out(co), .auto_ind_out(ind));
    panel_model #(.HOLD(8)) u_panel_model (.core_clk_in(clk), .close_in(cl), .contact_out(cont));
    initial forever #20 clk = ~clk;
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge clk) begin rd <= !w; wr <= w; adr <= a; wd <= d; end
        i = 0;
        do begin @(posedge clk); i++; end while (wreq !== 1'b0 && i < 20);
        q = rdat;
        rd <= 0;
        wr <= 0;
        if (wreq !== 1'b0) begin fail_count++; close_out(); end
    endtask
    task cyc(input int n); repeat (n) @(posedge clk); endtask
    task ticks(input int n);
        repeat (n) begin @(posedge clk) tick <= 1; @(posedge clk) tick <= 0; end
        cyc(5);
    endtask
    task t_restart;
        cyc(20); chk(ind, 1'b0);
        @(posedge clk) cl <= 1; @(posedge clk) cl <= 0;
        cyc(9); chk(ind, 1'b0);
        cyc(5); chk(ind, 1'b1);
        chk(ind, 1'b1);
        $display("restart done");
    endtask
    task t_force;
        @(posedge clk) begin f1 <= FORCE_ON; f2 <= FORCE_OFF; end
        cyc(3); chk(co, 2'b01);
        @(posedge clk) mode <= MODE_PROG2; cyc(3); chk(co, 2'b00);
        @(posedge clk) begin mode <= MODE_RUN; f1 <= FORCE_OFF; f2 <= FORCE_ON; end
        cyc(3); chk(co, 2'b10);
        @(posedge clk) begin f1 <= FORCE_AUTO; f2 <= FORCE_AUTO; end
        $display("force done");
    endtask
    task t_timer;
        bus(1, A_TIME, 32'h0000003b); bus(0, A_TIME, 0); chk(q, 32'h0000003b);
        bus(0, 6'h3c, 0); chk(q, 32'h0);
        @(posedge clk) mode <= MODE_PROG1;
        bus(1, A_SEL, 32'h0); bus(1, A_STAGE0, 32'h00200200);
        bus(1, A_CMD, 32'h8); bus(1, A_CMD, 32'h1);
        bus(1, A_SEL, 32'h1); bus(1, A_CMD, 32'h1); bus(1, A_CMD, 32'h14);
        bus(0, A_STATUS, 0); chk(q[13:7], 7'h01);
        chk(q[6:4], 3'h1);
        chk(q[16:14], 3'h1);
        bus(0, A_REVIEW, 0); chk(q[19:8], 12'h003);
        @(posedge clk) mode <= MODE_RUN;
        ticks(1); chk(co, 2'b01);
        bus(0, A_MONITOR, 0); chk(q, 32'h80200301);
        ticks(59); chk(co, 2'b01);
        ticks(1); chk(co, 2'b00);
        $display("timer done");
    endtask
    task t_cancel;
        bus(1, A_OVERRIDE, 32'h00000002); bus(0, A_STATUS, 0); chk(q[3], 1'b1);
        bus(1, A_CMD, 32'h2); bus(0, A_STATUS, 0); chk(q[3], 1'b0);
        @(posedge clk) mode <= MODE_PROG1;
        bus(1, A_CMD, 32'h2); bus(0, A_REVIEW, 0); chk(q[8], 1'b0);
        @(posedge clk) mode <= MODE_RUN;
        $display("cancel done");
    endtask
    task t_pulse;
        @(posedge clk) begin otype <= 1; mode <= MODE_PROG1; end
        bus(1, A_SEL, 32'h0); bus(1, A_STAGE0, 32'h00000600); bus(1, A_STAGE1, 32'h3);
        bus(1, A_CMD, 32'h1);
        @(posedge clk) mode <= MODE_RUN;
        bus(1, A_TIME, 32'h000000bb);
        ticks(1); chk(co, 2'b01);
        ticks(2); chk(co, 2'b01);
        ticks(1); chk(co, 2'b00);
        $display("pulse done");
    endtask
    task t_auto;
        @(posedge clk) begin ra <= 1; nrst <= 0; end
        cyc(3); @(posedge clk) nrst <= 1;
        @(posedge clk) chk(ind, 1'b0);
        cyc(2); chk(ind, 1'b1);
        $display("auto restart done");
    endtask
    initial begin
        cyc(5); @(posedge clk) nrst <= 1;
        t_restart(); t_force(); t_timer(); t_cancel(); t_pulse(); t_auto();
        close_out();
    end
endmodule // tb
